// >>> include/rps_defs.svh
`ifndef RPS_DEFS_SVH
`define RPS_DEFS_SVH

`define RPS_ADDR_UP_ORDER 8'h09
`define RPS_ADDR_UP_DELAYS 8'h0A
`define RPS_ADDR_DN_ORDER 8'h0B
`define RPS_ADDR_DN_DELAYS 8'h0C
`define RPS_ADDR_PG_STATUS 8'h0F

`define RPS_RST_UP_ORDER 8'hE4
`define RPS_RST_UP_DELAYS 8'h55
`define RPS_RST_DN_ORDER 8'h1E
`define RPS_RST_DN_DELAYS 8'hE0

`define RPS_DN_FIRST_BIT 1
`define RPS_DN_SCALE_BIT 0
`define RPS_DN_SCALE_SHIFT 4
`define RPS_UP_TICK_ADD 9'h001
`define RPS_DN_BASE_TICKS 9'h002
`define RPS_ONE_TICK 9'h001
`define RPS_LAST_STEP 2'h3
`define RPS_FIRST_STEP 2'h0
`define RPS_STEP_INC 2'h1

`define RPS_PG_GATE_HIGH_BIT 6
`define RPS_PG_INV_CONV_BIT 5
`define RPS_PG_SOURCE_POS_BIT 4
`define RPS_PG_GATE_LOW_BIT 3
`define RPS_PG_SOURCE_NEG_BIT 1

`define RPS_CLK_MHZ 125
`define RPS_BASE_MS 3

`endif

// >>> include/rps_pkg.sv
package rps_pkg;
	typedef enum logic [2:0] {
		S_OFF,
		S_WAIT_INV_PG,
		S_UP_DLY,
		S_ON,
		S_DN_DLY
	} rps_state_type;
endpackage : rps_pkg

// >>> rtl/rps_ms_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "rps_defs.svh"

module rps_ms_timer #(
	parameter int BASE_CYCLES = 375000
) (
	input wire logic clk, // system clock
	input wire logic reset, // async reset, high
	input wire logic start, // load and run, one-cycle pulse
	input wire logic [8:0] ticks, // delay in base ticks
	output logic done // one-cycle pulse at expiry
);
	localparam int PRE_W = $clog2(BASE_CYCLES);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(BASE_CYCLES - 1);

	logic [PRE_W-1:0] pre_ff;
	logic [8:0] cnt_ff;
	logic busy_ff;

	// a fresh start restarts the prescaler too, so delays are exact multiples
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pre_ff <= '0;
			cnt_ff <= 9'h000;
			busy_ff <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				pre_ff <= '0;
				cnt_ff <= ticks;
				busy_ff <= 1'b1;
			end else if (busy_ff) begin
				if (pre_ff == PRE_LAST) begin
					pre_ff <= '0;
					if (cnt_ff == `RPS_ONE_TICK) begin
						busy_ff <= 1'b0;
						done <= 1'b1;
					end else begin
						cnt_ff <= cnt_ff - `RPS_ONE_TICK;
					end
				end else begin
					pre_ff <= pre_ff + PRE_W'(1);
				end
			end
		end
	end

	a_timer_expiry: assert property (@(posedge clk) disable iff (reset)
		(busy_ff && !start && pre_ff == PRE_LAST && cnt_ff == `RPS_ONE_TICK) |=> (done && !busy_ff))
		else $error("timer did not expire on last tick");
endmodule : rps_ms_timer
`default_nettype wire

// >>> rtl/rps_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
`include "rps_defs.svh"

module rps_sequencer #(
	parameter int BASE_TICK_CYCLES = `RPS_BASE_MS * 1000 * `RPS_CLK_MHZ
) (
	input wire logic clk, // system clock
	input wire logic reset, // async reset, high
	input wire logic reg_wr, // register write strobe
	input wire logic reg_rd, // register read strobe
	input wire logic [7:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // write data
	output logic [7:0] reg_rdata, // read data, valid cycle after reg_rd
	input wire logic wake_input, // high requests power up
	input wire logic inverting_converter_power_good, // inverting converter in regulation
	input wire logic gate_high_pg, // gate high rail good
	input wire logic source_pos_pg, // source positive rail good
	input wire logic gate_low_pg, // gate low rail good
	input wire logic source_neg_pg, // source negative rail good
	output logic inv_conv_en, // inverting converter enable
	output logic gate_high_rail_en, // gate high rail enable
	output logic source_positive_rail_en, // source positive rail enable
	output logic gate_low_rail_en, // gate low rail enable
	output logic source_negative_rail_en, // source negative rail enable
	output logic [3:0] sequence_step, // step 1..4 pulses, bit 0 is step 1
	output logic sequence_up, // direction of last step pulse
	output logic power_good_output_out, // open-drain data, always low
	output logic power_good_output_oe // high pulls power good low
);
	logic [7:0] up_order_ff;
	logic [7:0] up_delays_ff;
	logic [7:0] dn_order_ff;
	logic [7:0] dn_delays_ff;
	rps_pkg::rps_state_type state_ff;
	logic [1:0] step_ff;
	logic tmr_start_ff;
	logic [8:0] tmr_ticks_ff;
	logic tmr_done;
	logic tmr_fire;
	logic [3:0] rail_en_ff;
	logic [3:0] rail_pg;
	logic all_good;

	// rail index: 0 source neg, 1 gate low, 2 source pos, 3 gate high
	assign rail_pg = {gate_high_pg, source_pos_pg, gate_low_pg, source_neg_pg};
	assign all_good = &rail_pg;
	// a done already in flight when a fresh start lands belongs to the cut run, not the new one
	assign tmr_fire = tmr_done && !tmr_start_ff;
	assign gate_high_rail_en = rail_en_ff[3];
	assign source_positive_rail_en = rail_en_ff[2];
	assign gate_low_rail_en = rail_en_ff[1];
	assign source_negative_rail_en = rail_en_ff[0];
	assign power_good_output_out = 1'b0;

	function automatic logic [1:0] fld(input logic [7:0] r, input logic [1:0] i);
		fld = 2'(r >> {i, 1'b0});
	endfunction : fld

	function automatic logic [8:0] up_ticks(input logic [1:0] code);
		up_ticks = {7'h00, code} + `RPS_UP_TICK_ADD;
	endfunction : up_ticks

	function automatic logic [8:0] dn_ticks(input logic [1:0] code, input logic scale);
		logic [8:0] t;
		t = `RPS_DN_BASE_TICKS << code;
		dn_ticks = scale ? 9'(t << `RPS_DN_SCALE_SHIFT) : t;
	endfunction : dn_ticks

	function automatic logic [8:0] dn_first(input logic [7:0] r);
		dn_first = r[`RPS_DN_FIRST_BIT] ? `RPS_DN_BASE_TICKS : `RPS_ONE_TICK;
	endfunction : dn_first

	// registers; changes during a running sequence take effect at the next step
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			up_order_ff <= `RPS_RST_UP_ORDER;
			up_delays_ff <= `RPS_RST_UP_DELAYS;
			dn_order_ff <= `RPS_RST_DN_ORDER;
			dn_delays_ff <= `RPS_RST_DN_DELAYS;
		end else if (reg_wr) begin
			if (reg_addr == `RPS_ADDR_UP_ORDER) begin
				up_order_ff <= reg_wdata;
			end else if (reg_addr == `RPS_ADDR_UP_DELAYS) begin
				up_delays_ff <= reg_wdata;
			end else if (reg_addr == `RPS_ADDR_DN_ORDER) begin
				dn_order_ff <= reg_wdata;
			end else if (reg_addr == `RPS_ADDR_DN_DELAYS) begin
				dn_delays_ff <= reg_wdata;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == `RPS_ADDR_UP_ORDER) begin
				reg_rdata <= up_order_ff;
			end else if (reg_addr == `RPS_ADDR_UP_DELAYS) begin
				reg_rdata <= up_delays_ff;
			end else if (reg_addr == `RPS_ADDR_DN_ORDER) begin
				reg_rdata <= dn_order_ff;
			end else if (reg_addr == `RPS_ADDR_DN_DELAYS) begin
				reg_rdata <= dn_delays_ff;
			end else if (reg_addr == `RPS_ADDR_PG_STATUS) begin
				reg_rdata <= 8'h00;
				reg_rdata[`RPS_PG_GATE_HIGH_BIT] <= gate_high_pg;
				reg_rdata[`RPS_PG_INV_CONV_BIT] <= inverting_converter_power_good;
				reg_rdata[`RPS_PG_SOURCE_POS_BIT] <= source_pos_pg;
				reg_rdata[`RPS_PG_GATE_LOW_BIT] <= gate_low_pg;
				reg_rdata[`RPS_PG_SOURCE_NEG_BIT] <= source_neg_pg;
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	// sequencing; wake falling during the up delays aborts into power-down at step 1, while waiting for converter good it returns to off
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_ff <= rps_pkg::S_OFF;
			step_ff <= `RPS_FIRST_STEP;
			tmr_start_ff <= 1'b0;
			tmr_ticks_ff <= 9'h000;
			inv_conv_en <= 1'b0;
			sequence_step <= 4'h0;
			sequence_up <= 1'b0;
		end else begin
			tmr_start_ff <= 1'b0;
			sequence_step <= 4'h0;
			case (state_ff)
				rps_pkg::S_OFF: begin
					if (wake_input) begin
						inv_conv_en <= 1'b1;
						state_ff <= rps_pkg::S_WAIT_INV_PG;
					end
				end
				rps_pkg::S_WAIT_INV_PG: begin
					if (!wake_input) begin
						inv_conv_en <= 1'b0;
						state_ff <= rps_pkg::S_OFF;
					end else if (inverting_converter_power_good) begin
						step_ff <= `RPS_FIRST_STEP;
						tmr_start_ff <= 1'b1;
						tmr_ticks_ff <= up_ticks(fld(up_delays_ff, `RPS_FIRST_STEP));
						state_ff <= rps_pkg::S_UP_DLY;
					end
				end
				rps_pkg::S_UP_DLY: begin
					if (!wake_input) begin
						step_ff <= `RPS_FIRST_STEP;
						tmr_start_ff <= 1'b1;
						tmr_ticks_ff <= dn_first(dn_delays_ff);
						state_ff <= rps_pkg::S_DN_DLY;
					end else if (tmr_fire) begin
						sequence_step[step_ff] <= 1'b1;
						sequence_up <= 1'b1;
						if (step_ff == `RPS_LAST_STEP) begin
							state_ff <= rps_pkg::S_ON;
						end else begin
							step_ff <= step_ff + `RPS_STEP_INC;
							tmr_start_ff <= 1'b1;
							tmr_ticks_ff <= up_ticks(fld(up_delays_ff, step_ff + `RPS_STEP_INC));
						end
					end
				end
				rps_pkg::S_ON: begin
					if (!wake_input) begin
						step_ff <= `RPS_FIRST_STEP;
						tmr_start_ff <= 1'b1;
						tmr_ticks_ff <= dn_first(dn_delays_ff);
						state_ff <= rps_pkg::S_DN_DLY;
					end
				end
				rps_pkg::S_DN_DLY: begin
					if (tmr_fire) begin
						sequence_step[step_ff] <= 1'b1;
						sequence_up <= 1'b0;
						if (step_ff == `RPS_LAST_STEP) begin
							inv_conv_en <= 1'b0;
							state_ff <= rps_pkg::S_OFF;
						end else begin
							step_ff <= step_ff + `RPS_STEP_INC;
							tmr_start_ff <= 1'b1;
							tmr_ticks_ff <= dn_ticks(fld(dn_delays_ff, step_ff + `RPS_STEP_INC),
								dn_delays_ff[`RPS_DN_SCALE_BIT]);
						end
					end
				end
				default: begin
					state_ff <= rps_pkg::S_OFF;
				end
			endcase
		end
	end

	rps_ms_timer #(
		.BASE_CYCLES(BASE_TICK_CYCLES)
	) u_timer (
		.clk(clk),
		.reset(reset),
		.start(tmr_start_ff),
		.ticks(tmr_ticks_ff),
		.done(tmr_done)
	);

	// every rail whose code matches the pulsed step switches in the same edge
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_rail
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					rail_en_ff[gi] <= 1'b0;
				end else if (sequence_up && sequence_step[fld(up_order_ff, 2'(gi))]) begin
					rail_en_ff[gi] <= 1'b1;
				end else if (!sequence_up && sequence_step[fld(dn_order_ff, 2'(gi))]) begin
					rail_en_ff[gi] <= 1'b0;
				end
			end

			a_up_rail_order: assert property (@(posedge clk) disable iff (reset)
				$rose(rail_en_ff[gi]) |-> $past(sequence_up)
				&& $past(sequence_step[fld(up_order_ff, 2'(gi))]))
				else $error("rail enabled on wrong step");
			a_dn_rail_order: assert property (@(posedge clk) disable iff (reset)
				$fell(rail_en_ff[gi]) |-> !$past(sequence_up)
				&& $past(sequence_step[fld(dn_order_ff, 2'(gi))]))
				else $error("rail disabled on wrong step");
		end
	endgenerate

	// registered so a glitch on one good input cannot flicker the pin
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			power_good_output_oe <= 1'b1;
		end else begin
			power_good_output_oe <= !all_good;
		end
	end

	a_pg_release: assert property (@(posedge clk) disable iff (reset)
		!all_good |=> power_good_output_oe && !power_good_output_out)
		else $error("power good released while a rail is bad");
	a_rst_up_order: assert property (@(posedge clk) disable iff (reset)
		$past(reset) |-> up_order_ff == `RPS_RST_UP_ORDER)
		else $error("up order reset value wrong");
	a_rst_dn_order: assert property (@(posedge clk) disable iff (reset)
		$past(reset) |-> dn_order_ff == `RPS_RST_DN_ORDER)
		else $error("down order reset value wrong");
	a_rst_delays: assert property (@(posedge clk) disable iff (reset)
		$past(reset) |-> up_delays_ff == `RPS_RST_UP_DELAYS
		&& dn_delays_ff == `RPS_RST_DN_DELAYS)
		else $error("delay reset values wrong");
	a_up_first_dly: assert property (@(posedge clk) disable iff (reset)
		(state_ff == rps_pkg::S_WAIT_INV_PG && wake_input && inverting_converter_power_good)
		|=> tmr_start_ff
		&& tmr_ticks_ff == {7'h00, fld(up_delays_ff, `RPS_FIRST_STEP)} + `RPS_UP_TICK_ADD)
		else $error("first up delay wrong");
	a_up_step_dly: assert property (@(posedge clk) disable iff (reset)
		(state_ff == rps_pkg::S_UP_DLY && tmr_start_ff && step_ff != `RPS_FIRST_STEP)
		|-> tmr_ticks_ff == {7'h00, fld(up_delays_ff, step_ff)} + `RPS_UP_TICK_ADD)
		else $error("up step delay wrong");
	a_dn_step_dly: assert property (@(posedge clk) disable iff (reset)
		(state_ff == rps_pkg::S_DN_DLY && tmr_start_ff && step_ff != `RPS_FIRST_STEP)
		|-> tmr_ticks_ff == 9'((`RPS_DN_BASE_TICKS << fld(dn_delays_ff, step_ff))
		<< (dn_delays_ff[`RPS_DN_SCALE_BIT] ? `RPS_DN_SCALE_SHIFT : 0)))
		else $error("down step delay wrong");
	a_dn_scale: assert property (@(posedge clk) disable iff (reset)
		(state_ff == rps_pkg::S_DN_DLY && tmr_start_ff && step_ff != `RPS_FIRST_STEP
		&& dn_delays_ff[`RPS_DN_SCALE_BIT]) |-> tmr_ticks_ff[3:0] == 4'h0)
		else $error("down scale not applied");
	a_dn_first_dly: assert property (@(posedge clk) disable iff (reset)
		((state_ff == rps_pkg::S_ON || state_ff == rps_pkg::S_UP_DLY) && !wake_input)
		|=> tmr_start_ff && state_ff == rps_pkg::S_DN_DLY
		&& tmr_ticks_ff == (dn_delays_ff[`RPS_DN_FIRST_BIT] ? `RPS_DN_BASE_TICKS : `RPS_ONE_TICK))
		else $error("wake low did not start power-down");
	a_step_ascend: assert property (@(posedge clk) disable iff (reset)
		(sequence_step != 4'h0) |-> $onehot(sequence_step)
		&& sequence_step[$past(step_ff)])
		else $error("step pulse not single or out of order");
endmodule : rps_sequencer
`default_nettype wire

// >>> testbench/rps_rail_model.sv
`timescale 1ns/100ps
`default_nettype none

module rps_rail_model (
	input wire logic clk, // system clock
	input wire logic reset, // async reset, high
	input wire logic conv_en, // inverting converter enable
	input wire logic [3:0] rail_en, // enables, bit 0 source neg .. bit 3 gate high
	input wire logic [3:0] rail_fail, // rails held out of regulation
	output logic conv_good, // converter in regulation
	output logic [3:0] rail_good // rails in regulation
);
	logic [1:0] conv_cnt;
	logic [3:0] en_d;

	// converter settles slowly so the sequencer must really wait for it
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			conv_cnt <= 2'h0;
			conv_good <= 1'b0;
		end else begin
			conv_cnt <= !conv_en ? 2'h0 : (conv_cnt == 2'h3 ? conv_cnt : conv_cnt + 2'h1);
			conv_good <= conv_en && conv_cnt == 2'h3;
		end
	end

	// good drops at once on disable, no kinder than a real rail
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			en_d <= 4'h0;
			rail_good <= 4'h0;
		end else begin
			en_d <= rail_en;
			rail_good <= rail_en & en_d & ~rail_fail;
		end
	end
endmodule : rps_rail_model

`default_nettype wire

// >>> testbench/rps_sequencer_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "rps_defs.svh"
`define CHK(got, exp, msg) begin \
	n_tests++; \
	if ((got) !== (exp)) begin \
		bad_count++; \
		$display("[FAIL] %0t %s: got %0h exp %0h", $time, msg, got, exp); \
	end \
end

module rps_sequencer_bench;
	localparam int BASE = 4;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic wake_input = 1'b0;
	logic [3:0] rail_fail = 4'h0;
	logic conv_good;
	logic [3:0] rail_good;
	logic inv_conv_en;
	logic [3:0] rail_en;
	logic [3:0] sequence_step;
	logic sequence_up;
	logic good_out;
	logic good_oe;
	logic [3:0] en_q;
	logic wake_q;
	logic conv_q;
	int bad_count = 0;
	int n_tests = 0;
	int cyc = 0;
	int n_pulse = 0;
	int conv_t;
	int wake_t;
	int step_t[4];
	int rail_t[4];

	rps_sequencer #(.BASE_TICK_CYCLES(BASE)) i_rps_sequencer (.clk(clk), .reset(reset),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .wake_input(wake_input),
		.inverting_converter_power_good(conv_good), .gate_high_pg(rail_good[3]),
		.source_pos_pg(rail_good[2]), .gate_low_pg(rail_good[1]),
		.source_neg_pg(rail_good[0]), .inv_conv_en(inv_conv_en),
		.gate_high_rail_en(rail_en[3]), .source_positive_rail_en(rail_en[2]),
		.gate_low_rail_en(rail_en[1]), .source_negative_rail_en(rail_en[0]),
		.sequence_step(sequence_step), .sequence_up(sequence_up),
		.power_good_output_out(good_out), .power_good_output_oe(good_oe));

	rps_rail_model i_rps_rail_model (.clk(clk), .reset(reset), .conv_en(inv_conv_en),
		.rail_en(rail_en), .rail_fail(rail_fail), .conv_good(conv_good),
		.rail_good(rail_good));

	initial begin
		forever #4 clk = ~clk;
	end

	// event times in cycles, all taken at the same edge so offsets compare cleanly
	always @(posedge clk) begin
		for (int i = 0; i < 4; i++) begin
			if (sequence_step[i]) step_t[i] = cyc;
			if (rail_en[i] !== en_q[i]) rail_t[i] = cyc;
		end
		if (sequence_step != 4'h0) begin
			n_pulse++;
			`CHK($countones(sequence_step), 1, "step not one-hot")
		end
		if (conv_good && !conv_q) conv_t = cyc;
		if (!wake_input && wake_q) wake_t = cyc;
		en_q = rail_en;
		wake_q = wake_input;
		conv_q = conv_good;
		cyc++;
	end

	task automatic finish_test;
		$display("bad_count %0d n_tests %0d", bad_count, n_tests);
		if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : finish_test

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		`CHK(reg_rdata, e, "read data")
	endtask : reg_read

	task automatic wait_pulses;
		for (int i = 0; i < 8000 && n_pulse < 4; i++) @(negedge clk);
		if (n_pulse < 4) begin
			bad_count++;
			$display("[FAIL] %0t sequence stalled", $time);
			finish_test;
		end
		repeat (4) @(negedge clk);
	endtask : wait_pulses

	task automatic run_cycle(input logic [7:0] uo, input logic [7:0] ud, input logic [7:0] dno,
			input logic [7:0] dd);
		reg_write(`RPS_ADDR_UP_ORDER, uo);
		reg_write(`RPS_ADDR_UP_DELAYS, ud);
		reg_write(`RPS_ADDR_DN_ORDER, dno);
		reg_write(`RPS_ADDR_DN_DELAYS, dd);
		reg_read(`RPS_ADDR_DN_DELAYS, dd);
		n_pulse = 0;
		wake_input = 1'b1;
		wait_pulses;
		// first step lags one more cycle: the timer start itself is registered
		`CHK(step_t[0] - conv_t, 3 + (ud[1:0] + 1) * BASE, "up first delay")
		for (int k = 1; k < 4; k++) begin
			`CHK(step_t[k] - step_t[k-1], 2 + (ud[2*k +: 2] + 1) * BASE, "up delay")
		end
		for (int r = 0; r < 4; r++) begin
			`CHK(rail_t[r] - step_t[uo[2*r +: 2]], 1, "rail on step")
		end
		`CHK(sequence_up, 1'b1, "direction up")
		`CHK(good_oe, 1'b0, "good released")
		reg_read(`RPS_ADDR_PG_STATUS, 8'h7A);
		for (int r = 0; r < 4; r++) begin
			rail_fail = 4'(1 << r);
			repeat (3) @(negedge clk);
			`CHK(good_oe, 1'b1, "good with rail down")
			rail_fail = 4'h0;
			repeat (3) @(negedge clk);
		end
		`CHK(good_oe, 1'b0, "good back")
		n_pulse = 0;
		wake_input = 1'b0;
		wait_pulses;
		`CHK(step_t[0] - wake_t, 3 + (dd[1] ? 2 : 1) * BASE, "down first delay")
		for (int k = 1; k < 4; k++) begin
			`CHK(step_t[k] - step_t[k-1], 2 + ((2 << dd[2*k +: 2]) << (dd[0] ? 4 : 0)) * BASE,
				"down delay")
		end
		for (int r = 0; r < 4; r++) begin
			`CHK(rail_t[r] - step_t[dno[2*r +: 2]], 1, "rail off step")
		end
		`CHK(rail_en, 4'h0, "rails off")
		`CHK(inv_conv_en, 1'b0, "converter off")
		`CHK(sequence_up, 1'b0, "direction down")
		`CHK(good_oe, 1'b1, "good pulled low")
	endtask : run_cycle

	initial begin
		repeat (8) @(negedge clk);
		reset = 1'b0;
		`CHK(good_oe, 1'b1, "good at reset")
		`CHK(good_out, 1'b0, "good pin data")
		reg_read(`RPS_ADDR_UP_ORDER, 8'hE4);
		reg_read(`RPS_ADDR_UP_DELAYS, 8'h55);
		reg_read(`RPS_ADDR_DN_ORDER, 8'h1E);
		reg_read(`RPS_ADDR_DN_DELAYS, 8'hE0);
		reg_write(`RPS_ADDR_PG_STATUS, 8'hFF);
		reg_read(`RPS_ADDR_PG_STATUS, 8'h00);
		reg_read(8'h05, 8'h00);
		// defaults, then shared steps with slow scaled down, then every code reshuffled
		run_cycle(8'hE4, 8'h55, 8'h1E, 8'hE0);
		run_cycle(8'h00, 8'hE4, 8'hFF, 8'h1F);
		run_cycle(8'h1B, 8'h1B, 8'h4B, 8'h9C);
		// wake drops after two up steps; 9Ch keeps the 3 ms first down delay
		n_pulse = 0;
		wake_input = 1'b1;
		for (int i = 0; i < 8000 && n_pulse < 2; i++) @(negedge clk);
		`CHK(n_pulse, 2, "partial power-up")
		n_pulse = 0;
		wake_input = 1'b0;
		wait_pulses;
		`CHK(step_t[0] - wake_t, 3 + BASE, "mid-up first down delay")
		`CHK(rail_en, 4'h0, "mid-up rails off")
		`CHK(inv_conv_en, 1'b0, "mid-up converter off")
		`CHK(sequence_up, 1'b0, "mid-up direction")
		n_pulse = 0;
		wake_input = 1'b1;
		@(negedge clk);
		wake_input = 1'b0;
		repeat (10) @(negedge clk);
		`CHK(n_pulse, 0, "abort gave steps")
		`CHK(inv_conv_en, 1'b0, "abort converter")
		finish_test;
	end
endmodule : rps_sequencer_bench

`default_nettype wire
